/* File: verilog/sphz_pwm_top.sv */
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module sphz_pwm_top #(
	parameter int CNT_W = sphz_pkg::SPHZ_CNT_W,
	parameter int DT_W = sphz_pkg::SPHZ_DT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sphz_pkg::SPHZ_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sphz_pkg::SPHZ_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_pin_a,
	output sphz_pkg::sphz_pwm_s pwm_out,
	output logic crest_irq,
	output logic valley_irq
);
	import sphz_pkg::*;

	// Counter logic is fixed at 16 bits; dead time must be 1 to 16 bits wide
	if (CNT_W != 16 || DT_W < 1 || DT_W > 16) begin : g_bad_width
		$error("sphz_pwm_top: unsupported counter widths");
	end

	// Byte-lane merge for narrow registers
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Basic phase level; duty of M+2 or more gives the direction level, the comparisons decide below that
	function automatic logic phase_level(input logic [15:0] cnt, input logic dir,
			input logic [15:0] duty, input logic [15:0] m);
		logic [16:0] lim;
		lim = {1'b0, m} + 17'h00002;
		if ({1'b0, duty} >= lim) begin
			return dir;
		end
		// Duty 0 is high everywhere, M+1 nowhere
		return dir ? (cnt > duty) : (cnt >= duty);
	endfunction

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic aw_free_reg, w_free_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	wire aw_take = s_axi_awvalid & aw_free_reg;
	wire w_take = s_axi_wvalid & w_free_reg;
	wire wr_fire = ~aw_free_reg & ~w_free_reg & ~bvalid_reg;
	wire ar_take = s_axi_arvalid & arready_reg;

	wire wr_ctrl = wr_fire & (aw_addr_reg == SPHZ_CTRL_OFS);
	wire wr_cycle = wr_fire & (aw_addr_reg == SPHZ_CYCLE_OFS);
	wire wr_u = wr_fire & (aw_addr_reg == SPHZ_DUTY_U_OFS);
	wire wr_v = wr_fire & (aw_addr_reg == SPHZ_DUTY_V_OFS);
	wire wr_w = wr_fire & (aw_addr_reg == SPHZ_DUTY_W_OFS);
	wire wr_dead = wr_fire & (aw_addr_reg == SPHZ_DEAD_OFS);
	wire wr_cull = wr_fire & (aw_addr_reg == SPHZ_CULL_OFS);
	wire wr_hiz = wr_fire & (aw_addr_reg == SPHZ_HIZ_OFS) & w_strb_reg[0];
	wire wr_status = wr_fire & (aw_addr_reg == SPHZ_STATUS_OFS);
	wire wr_mapped = wr_ctrl | wr_cycle | wr_u | wr_v | wr_w | wr_dead | wr_cull | wr_status
		| (wr_fire & (aw_addr_reg == SPHZ_HIZ_OFS));

	// Channel handshakes; an address or data beat is held until the pair completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_free_reg <= 1'b1;
			w_free_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= SPHZ_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_free_reg <= 1'b0;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_free_reg <= 1'b1;
			end
			if (w_take) begin
				w_free_reg <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_free_reg <= 1'b1;
			end
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? SPHZ_RESP_OKAY : SPHZ_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers and buffers
	// ----------------------------------------------------------------
	logic [5:0] ctrl_reg;
	logic [15:0] buf_cycle_reg, act_cycle_reg;
	logic [15:0] buf_duty_reg [3];
	logic [15:0] act_duty_reg [3];
	logic [DT_W-1:0] dead_reg;
	logic [6:0] buf_cull_reg, act_cull_reg;
	logic xfer_pend_reg;
	sphz_hiz_cfg_s hiz_cfg_reg;
	logic hiz_flag_reg;

	wire running = ctrl_reg[SPHZ_CTRL_RUN]
		& (ctrl_reg[SPHZ_CTRL_MODE_LSB +: 3] == SPHZ_MODE_SIX_PHASE);
	wire anytime = ctrl_reg[SPHZ_CTRL_ANYTIME];
	wire intermit = ctrl_reg[SPHZ_CTRL_INTERMIT];

	// Byte-lane merged write words, one per narrow register
	wire [31:0] ctrl_wr = merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg);
	wire [31:0] cycle_wr = merge({16'h0, buf_cycle_reg}, w_data_reg, w_strb_reg);
	wire [31:0] u_wr = merge({16'h0, buf_duty_reg[0]}, w_data_reg, w_strb_reg);
	wire [31:0] v_wr = merge({16'h0, buf_duty_reg[1]}, w_data_reg, w_strb_reg);
	wire [31:0] w_wr = merge({16'h0, buf_duty_reg[2]}, w_data_reg, w_strb_reg);
	wire [31:0] dead_wr = merge(32'(dead_reg), w_data_reg, w_strb_reg);
	wire [31:0] cull_wr = merge({25'h0, buf_cull_reg}, w_data_reg, w_strb_reg);

	// Plain configuration writes; duty writes sit in the buffers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= SPHZ_CTRL_RST;
			buf_cycle_reg <= SPHZ_CYCLE_RST;
			buf_duty_reg <= '{default: SPHZ_DUTY_RST};
			dead_reg <= DT_W'(SPHZ_DEAD_RST);
			buf_cull_reg <= SPHZ_CULL_RST;
			hiz_cfg_reg <= '0;
		end else begin
			if (wr_ctrl) ctrl_reg <= ctrl_wr[5:0];
			if (wr_cycle) buf_cycle_reg <= cycle_wr[15:0];
			if (wr_u) buf_duty_reg[0] <= u_wr[15:0];
			if (wr_v) buf_duty_reg[1] <= v_wr[15:0];
			if (wr_w) buf_duty_reg[2] <= w_wr[15:0];
			if (wr_dead) dead_reg <= dead_wr[DT_W-1:0];
			if (wr_cull) buf_cull_reg <= cull_wr[6:0];
			// Settings taken whole; software disables first before changing them
			if (wr_hiz) hiz_cfg_reg <= sphz_hiz_cfg_s'(w_data_reg[SPHZ_HIZ_RISE +: 4]);
		end
	end

	// ----------------------------------------------------------------
	// Carrier counter, events and culling
	// ----------------------------------------------------------------
	logic [15:0] cnt_reg;
	logic dir_reg;
	logic [SPHZ_CULL_W-1:0] cull_cnt_reg;
	logic crest_irq_reg, valley_irq_reg;

	wire crest_evt = running & ~dir_reg & (cnt_reg == act_cycle_reg);
	wire valley_evt = running & dir_reg & (cnt_reg == SPHZ_VALLEY_CNT);
	wire cull_qual = (crest_evt & act_cull_reg[SPHZ_CULL_CREST_EN])
		| (valley_evt & act_cull_reg[SPHZ_CULL_VALLEY_EN]);
	wire cull_hit = cull_qual & (cull_cnt_reg == act_cull_reg[SPHZ_CULL_W-1:0]);
	// Anytime copies every cycle; batch at turning points; intermittent at culled points
	wire xfer = anytime | ~running
		| (xfer_pend_reg & (intermit ? cull_hit : (crest_evt | valley_evt)));

	// Up to one past the cycle value, down to 0001H, then back to zero and up
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			cnt_reg <= 16'h0000;
			dir_reg <= 1'b0;
		end else if (!dir_reg) begin
			cnt_reg <= cnt_reg + 16'h0001;
			if (crest_evt) dir_reg <= 1'b1;
		end else if (valley_evt) begin
			cnt_reg <= 16'h0000;
			dir_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	// Culling counter and culled event pulses
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			cull_cnt_reg <= '0;
			crest_irq_reg <= 1'b0;
			valley_irq_reg <= 1'b0;
		end else begin
			if (cull_qual) cull_cnt_reg <= cull_hit ? '0 : cull_cnt_reg + 1'b1;
			crest_irq_reg <= cull_hit & crest_evt;
			valley_irq_reg <= cull_hit & valley_evt;
		end
	end

	// Buffer transfer; a new U duty write during the wait re-arms, so set wins over the transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_cycle_reg <= SPHZ_CYCLE_RST;
			act_duty_reg <= '{default: SPHZ_DUTY_RST};
			act_cull_reg <= SPHZ_CULL_RST;
			xfer_pend_reg <= 1'b0;
		end else begin
			if (xfer) begin
				act_cycle_reg <= buf_cycle_reg;
				act_duty_reg <= buf_duty_reg;
				act_cull_reg <= buf_cull_reg;
			end
			// Writing the U duty last commits the whole set
			if (wr_u) xfer_pend_reg <= 1'b1;
			else if (xfer) xfer_pend_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Dead time and outputs
	// ----------------------------------------------------------------
	logic [2:0] raw_reg;
	logic [DT_W-1:0] dt_cnt_reg [3];
	logic [2:0] raw_now;
	logic [2:0] dt_done;
	sphz_pwm_s pwm_reg;

	for (genvar p = 0; p < 3; p++) begin : g_phase
		assign raw_now[p] = running & phase_level(cnt_reg, dir_reg, act_duty_reg[p], act_cycle_reg);
		assign dt_done[p] = (dt_cnt_reg[p] == dead_reg);

		// Each phase restarts its own count on every edge of its basic wave
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				raw_reg[p] <= 1'b0;
				dt_cnt_reg[p] <= '0;
			end else begin
				raw_reg[p] <= raw_now[p];
				if (raw_now[p] != raw_reg[p]) dt_cnt_reg[p] <= '0;
				else if (!dt_done[p]) dt_cnt_reg[p] <= dt_cnt_reg[p] + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shutdown controller
	// ----------------------------------------------------------------
	logic fault_prev_reg;

	wire edge_sel_ok = ~(hiz_cfg_reg.edge_rise & hiz_cfg_reg.edge_fall);
	wire fault_edge = hiz_cfg_reg.enable & edge_sel_ok
		& ((hiz_cfg_reg.edge_rise & fault_pin_a & ~fault_prev_reg)
		| (hiz_cfg_reg.edge_fall & ~fault_pin_a & fault_prev_reg));
	wire fault_active = edge_sel_ok
		& ((hiz_cfg_reg.edge_rise & fault_pin_a) | (hiz_cfg_reg.edge_fall & ~fault_pin_a));
	wire trig_cmd = wr_hiz & w_data_reg[SPHZ_HIZ_TRIG] & hiz_cfg_reg.enable;
	wire clr_cmd = wr_hiz & w_data_reg[SPHZ_HIZ_CLR] & hiz_cfg_reg.enable
		& ~(hiz_cfg_reg.clear_mode & fault_active);
	// Disabling write drops the flag at the same edge the enable falls
	wire hiz_off = ~hiz_cfg_reg.enable | (wr_hiz & ~w_data_reg[SPHZ_HIZ_EN]);

	// Disable beats everything; any set beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_prev_reg <= 1'b0;
			hiz_flag_reg <= 1'b0;
		end else begin
			fault_prev_reg <= fault_pin_a;
			if (hiz_off) hiz_flag_reg <= 1'b0;
			else if (fault_edge) hiz_flag_reg <= 1'b1;
			else if (trig_cmd) hiz_flag_reg <= 1'b1;
			else if (clr_cmd) hiz_flag_reg <= 1'b0;
		end
	end

	// Drives are registered; shutdown drops the enable and parks the levels low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_reg <= '0;
		end else begin
			pwm_reg.drive_en <= ~hiz_flag_reg;
			pwm_reg.top <= hiz_flag_reg ? 3'b000 : raw_reg & dt_done;
			pwm_reg.bot <= hiz_flag_reg ? 3'b000 : ~raw_reg & dt_done & {3{running}};
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
	wire [7:0] hiz_rd = {hiz_cfg_reg, 3'b000, hiz_flag_reg};
	logic [31:0] rd_mux;
	logic rd_hit;

	// Read decode; unmapped words answer SLVERR with zero data
	always_comb begin
		rd_hit = 1'b1;
		unique case (ar_addr)
			SPHZ_CTRL_OFS: rd_mux = {26'h0, ctrl_reg};
			SPHZ_CYCLE_OFS: rd_mux = {16'h0, buf_cycle_reg};
			SPHZ_DUTY_U_OFS: rd_mux = {16'h0, buf_duty_reg[0]};
			SPHZ_DUTY_V_OFS: rd_mux = {16'h0, buf_duty_reg[1]};
			SPHZ_DUTY_W_OFS: rd_mux = {16'h0, buf_duty_reg[2]};
			SPHZ_DEAD_OFS: rd_mux = 32'(dead_reg);
			SPHZ_CULL_OFS: rd_mux = {25'h0, buf_cull_reg};
			SPHZ_STATUS_OFS: rd_mux = {cnt_reg, 14'h0, running, dir_reg};
			SPHZ_HIZ_OFS: rd_mux = {24'h0, hiz_rd};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// One read outstanding; the address is refused while the answer stands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= SPHZ_RESP_OKAY;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? SPHZ_RESP_OKAY : SPHZ_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_awready = aw_free_reg;
	assign s_axi_wready = w_free_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign pwm_out = pwm_reg;
	assign crest_irq = crest_irq_reg;
	assign valley_irq = valley_irq_reg;

endmodule

/* File: verilog/sphz_pkg.sv */
package sphz_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SPHZ_ADDR_W = 8;
	localparam int SPHZ_CNT_W = 16;
	localparam int SPHZ_DT_W = 10;
	localparam int SPHZ_CULL_W = 5;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SPHZ_CTRL_OFS = 8'h00;
	localparam logic [7:0] SPHZ_CYCLE_OFS = 8'h04;
	localparam logic [7:0] SPHZ_DUTY_U_OFS = 8'h08;
	localparam logic [7:0] SPHZ_DUTY_V_OFS = 8'h0C;
	localparam logic [7:0] SPHZ_DUTY_W_OFS = 8'h10;
	localparam logic [7:0] SPHZ_DEAD_OFS = 8'h14;
	localparam logic [7:0] SPHZ_CULL_OFS = 8'h18;
	localparam logic [7:0] SPHZ_STATUS_OFS = 8'h1C;
	localparam logic [7:0] SPHZ_HIZ_OFS = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SPHZ_CTRL_RUN = 0;
	localparam int SPHZ_CTRL_MODE_LSB = 1;
	localparam int SPHZ_CTRL_ANYTIME = 4;
	localparam int SPHZ_CTRL_INTERMIT = 5;
	localparam int SPHZ_CULL_CREST_EN = 5;
	localparam int SPHZ_CULL_VALLEY_EN = 6;
	localparam int SPHZ_STAT_DIR = 0;
	localparam int SPHZ_STAT_RUN = 1;
	localparam int SPHZ_STAT_CNT_LSB = 16;
	localparam int SPHZ_HIZ_EN = 7;
	localparam int SPHZ_HIZ_MODE = 6;
	localparam int SPHZ_HIZ_FALL = 5;
	localparam int SPHZ_HIZ_RISE = 4;
	localparam int SPHZ_HIZ_TRIG = 3;
	localparam int SPHZ_HIZ_CLR = 2;
	localparam int SPHZ_HIZ_FLAG = 0;

	// ----------------------------------------------------------------
	// Values after reset and codes
	// ----------------------------------------------------------------
	localparam logic [5:0] SPHZ_CTRL_RST = 6'h00;
	localparam logic [15:0] SPHZ_CYCLE_RST = 16'h0002;
	localparam logic [15:0] SPHZ_DUTY_RST = 16'h0000;
	localparam logic [9:0] SPHZ_DEAD_RST = 10'h000;
	localparam logic [6:0] SPHZ_CULL_RST = 7'h60;
	localparam logic [7:0] SPHZ_HIZ_RST = 8'h00;
	localparam logic [2:0] SPHZ_MODE_SIX_PHASE = 3'h7;
	localparam logic [15:0] SPHZ_VALLEY_CNT = 16'h0001;
	localparam logic [1:0] SPHZ_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPHZ_RESP_SLVERR = 2'h2;

	// Six gate drives plus the common drive enable
	typedef struct packed {
		logic [2:0] top;
		logic [2:0] bot;
		logic drive_en;
	} sphz_pwm_s;

	// Shutdown controller settings
	typedef struct packed {
		logic enable;
		logic clear_mode;
		logic edge_fall;
		logic edge_rise;
	} sphz_hiz_cfg_s;

endpackage

/* File: test/sphz_power_stage.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Power stage and fault sensor seen from the gate pins
// ----------------------------------------------------------------
module sphz_power_stage (
	input wire logic aclk,
	input wire logic fault_level,
	input wire sphz_pkg::sphz_pwm_s pwm_out,
	output logic fault_pin_a,
	output logic [2:0] gate_top,
	output logic [2:0] gate_bot
);
	import sphz_pkg::*;

	// Sensor output changes just after a clock edge, like a real comparator
	initial fault_pin_a = 1'h0;
	always @(posedge aclk) begin
		fault_pin_a <= fault_level;
	end

	// Gate pull-downs: a released pin reads low, never the last level
	assign gate_top = pwm_out.drive_en ? pwm_out.top : 3'h0;
	assign gate_bot = pwm_out.drive_en ? pwm_out.bot : 3'h0;
endmodule

/* File: test/sphz_pwm_asserts.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module sphz_pwm_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sphz_pkg::SPHZ_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire sphz_pkg::sphz_pwm_s pwm_out,
	input wire logic crest_irq,
	input wire logic valley_irq
);
	import sphz_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Both write channels taken at one edge
	sequence wr_go;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Full-byte write to the shutdown control register
	sequence hiz_wr;
		wr_go ##0 (s_axi_awaddr == SPHZ_HIZ_OFS && s_axi_wstrb[0]);
	endsequence

	// Enable as last written; a trigger counts only if already enabled
	logic en_seen;
	wire hiz_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == SPHZ_HIZ_OFS && s_axi_wstrb[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_seen <= 1'b0;
		end else if (hiz_take) begin
			en_seen <= s_axi_wdata[SPHZ_HIZ_EN];
		end
	end

	wr_answer_a: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	bad_addr_a: assert property (wr_go ##0 s_axi_awaddr == 8'h40
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == SPHZ_RESP_SLVERR))
		else $error("unmapped write not refused");
	irq_pulse_a: assert property (
		(crest_irq || valley_irq) |=> !(crest_irq || valley_irq))
		else $error("event pulse too long");
	hiz_levels_a: assert property (
		!pwm_out.drive_en |-> (pwm_out.top == 3'h0 && pwm_out.bot == 3'h0))
		else $error("levels active while released");
	no_overlap_a: assert property ((pwm_out.top & pwm_out.bot) == 3'h0)
		else $error("both gates of a phase on");
	trig_off_a: assert property (
		hiz_wr ##0 (en_seen && s_axi_wdata[SPHZ_HIZ_EN] && s_axi_wdata[SPHZ_HIZ_TRIG])
		|-> ##[1:4] !pwm_out.drive_en)
		else $error("trigger did not release pins");
	clr_on_a: assert property (
		hiz_wr ##0 (s_axi_wdata[7:6] == 2'h2 && s_axi_wdata[3:2] == 2'h1)
		|-> ##[1:5] pwm_out.drive_en)
		else $error("clear did not restore drive");
	dis_on_a: assert property (
		hiz_wr ##0 !s_axi_wdata[SPHZ_HIZ_EN] |-> ##[1:5] pwm_out.drive_en)
		else $error("disable did not restore drive");
endmodule

bind sphz_pwm_top sphz_pwm_asserts i_sphz_pwm_asserts (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .pwm_out, .crest_irq, .valley_irq);

/* File: test/sphz_pwm_top_tb_top.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("wrong value at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module sphz_pwm_top_tb_top;
	import sphz_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, fault_level, fault_pin_a;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic crest_irq, valley_irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] gate_top, gate_bot;
	logic [6:0] p_and, p_or;
	sphz_pwm_s pwm_out;
	int err_count, tests_run, cycles, n;

	sphz_pwm_top i_sphz_pwm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fault_pin_a, .pwm_out, .crest_irq, .valley_irq);
	sphz_power_stage i_sphz_power_stage (.aclk, .fault_level, .pwm_out, .fault_pin_a,
		.gate_top, .gate_bot);

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	// Whole run needs about four hundred cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Write the shutdown control and read it straight back
	task automatic hz(input logic [31:0] d, input logic [7:0] e);
		axi_wr(SPHZ_HIZ_OFS, d);
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat, {24'h0, e})
	endtask
	// Sensor level change; pin register plus edge detect need two edges
	task automatic pin(input logic v);
		@(posedge aclk);
		fault_level <= v;
		repeat (4) @(posedge aclk);
	endtask
	// Cycles up to the next crest (v=0) or valley (v=1) pulse
	task automatic to_irq(input logic v);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (v ? !valley_irq : !crest_irq);
	endtask
	task finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		fault_level = 1'h0;
		aresetn = 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat, 32'h0)
		axi_rd(8'h40);
		`CHK(rsp, SPHZ_RESP_SLVERR)
		axi_wr(8'h40, 32'h1);
		`CHK(rsp, SPHZ_RESP_SLVERR)
		$display("test map done");
		// Running with mode 000 must not produce carrier events
		axi_wr(SPHZ_CTRL_OFS, 32'h1);
		n = 0;
		repeat (40) begin
			@(posedge aclk);
			if (crest_irq | valley_irq) n++;
		end
		`CHK(n, 0)
		$display("test mode done");
		// m=4: U full on, V full off, W at half; V,W,cycle before U
		axi_wr(SPHZ_DUTY_V_OFS, 32'h5);
		axi_wr(SPHZ_DUTY_W_OFS, 32'h6);
		axi_wr(SPHZ_CYCLE_OFS, 32'h4);
		axi_wr(SPHZ_DEAD_OFS, 32'h1);
		axi_wr(SPHZ_DUTY_U_OFS, 32'h0);
		axi_wr(SPHZ_CTRL_OFS, 32'h1F);
		to_irq(1'h0);
		to_irq(1'h1);
		`CHK(n, 5)
		to_irq(1'h0);
		`CHK(n, 5)
		p_and = 7'h7F;
		p_or = 7'h00;
		repeat (10) begin
			@(posedge aclk);
			p_and = p_and & pwm_out;
			p_or = p_or | pwm_out;
		end
		`CHK(p_and, 7'h15)
		`CHK(p_or, 7'h5D)
		repeat (6) begin
			axi_rd(SPHZ_STATUS_OFS);
			n = rdat[0] ? (rdat[31:16] >= 16'h1 && rdat[31:16] <= 16'h5) : rdat[31:16] <= 16'h4;
			`CHK(n, 1)
		end
		// Batch rewrite: a new cycle waits for a turning point after the U write
		axi_wr(SPHZ_CTRL_OFS, 32'h0F);
		axi_wr(SPHZ_CYCLE_OFS, 32'h6);
		to_irq(1'h0);
		to_irq(1'h1);
		`CHK(n, 5)
		axi_wr(SPHZ_DUTY_U_OFS, 32'h0);
		to_irq(1'h0);
		to_irq(1'h1);
		to_irq(1'h0);
		`CHK(n, 7)
		to_irq(1'h1);
		`CHK(n, 7)
		$display("test carrier done");
		hz(32'h08, 8'h00);
		hz(32'h80, 8'h80);
		hz(32'h88, 8'h81);
		`CHK(gate_top, 3'h0)
		hz(32'h84, 8'h80);
		hz(32'h00, 8'h00);
		hz(32'h10, 8'h10);
		hz(32'h90, 8'h90);
		pin(1'h1);
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat[7:0], 8'h91)
		hz(32'h94, 8'h90);
		pin(1'h0);
		hz(32'h00, 8'h00);
		hz(32'h50, 8'h50);
		hz(32'hD0, 8'hD0);
		pin(1'h1);
		hz(32'hD4, 8'hD1);
		pin(1'h0);
		n = 0;
		do begin
			axi_wr(SPHZ_HIZ_OFS, 32'hD4);
			axi_rd(SPHZ_HIZ_OFS);
			n++;
		end while (rdat[0] && n < 4);
		`CHK(rdat[7:0], 8'hD0)
		hz(32'h00, 8'h00);
		hz(32'h20, 8'h20);
		hz(32'hA0, 8'hA0);
		pin(1'h1);
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat[7:0], 8'hA0)
		pin(1'h0);
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat[7:0], 8'hA1)
		hz(32'h00, 8'h00);
		hz(32'h80, 8'h80);
		pin(1'h1);
		axi_rd(SPHZ_HIZ_OFS);
		`CHK(rdat[7:0], 8'h80)
		pin(1'h0);
		$display("test shutdown done");
		finish_test();
	end
endmodule
